// File: hw/titc_top.v
`timescale 1ns/1ps
`include "titc_defines.vh"
// How it works
// RULE_01: three separate 16-bit configurable counters
// RULE_02: binary or decimal count per counter
// RULE_03: seven counting functions selectable per counter
// RULE_04: third counter makes the serial bit clock
// RULE_05: general outputs routed to irq or port
// RULE_06: general gates from terminator or port line
// RULE_07: terminal count raises interrupt request
// RULE_08: retriggerable one-shot, low until terminal count
// RULE_09: rate generator, one low tick per N
// RULE_10: square wave, high half then low half
// RULE_11: software strobe pulses low N counts later
// RULE_12: hardware strobe, retriggered by gate rise
// RULE_13: event counting from external event input
// RULE_14: live read plus latch command on fly
// RULE_15: decrement per tick while gate permits
module titc_top #(
  parameter WIDTH = 16,
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // external event clocks and gates
  input wire [2:0] evt_in,
  input wire [1:0] gate_term_in,
  input wire [1:0] gate_pio_in,
  // routed timer outputs
  output reg [1:0] tmr_irq_out,
  output reg [1:0] port_drv_out,
  output reg [1:0] port_in_out,
  output reg baud_clk_out,
  // interrupt
  output reg irq
);

  localparam [3:0] SEL_CMD = 4'h8;
  localparam [3:0] SEL_STAT = 4'h9;
  localparam [3:0] SEL_MASK = 4'ha;
  localparam [3:0] SEL_PRE = 4'hb;
  localparam [3:0] SEL_NONE = 4'hf;

  // address to register code, shared by read and write
  function [3:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `TITC_CTRL0_OFS: reg_sel = 4'h0;
        `TITC_CTRL1_OFS: reg_sel = 4'h1;
        `TITC_CTRL2_OFS: reg_sel = 4'h2;
        `TITC_LOAD0_OFS: reg_sel = 4'h4;
        `TITC_LOAD1_OFS: reg_sel = 4'h5;
        `TITC_LOAD2_OFS: reg_sel = 4'h6;
        `TITC_CMD_OFS: reg_sel = SEL_CMD;
        `TITC_STAT_OFS: reg_sel = SEL_STAT;
        `TITC_MASK_OFS: reg_sel = SEL_MASK;
        `TITC_PRE_OFS: reg_sel = SEL_PRE;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  reg [7:0] ctrl_reg [0:2];
  reg [2:0] stat_reg;
  reg [2:0] mask_reg;
  reg [15:0] pre_reg;
  reg [15:0] pre_cnt_reg;
  reg pre_tick_reg;
  reg [2:0] evt_d_reg;
  reg [31:0] rdata_next;
  reg [2:0] stat_next;

  wire [WIDTH*3-1:0] cnt_val;
  wire [2:0] cnt_out;
  wire [2:0] cnt_tc;
  wire [2:0] evt_rise = evt_in & ~evt_d_reg;

  // apb handshake, one wait cycle in every access
  wire acc = psel & penable;
  wire acc_first = acc & ~pready;
  wire done = acc & pready;
  wire wr_en = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire [3:0] sel = reg_sel(paddr);

  ////////////////////////////////////////////////////////////////////////////////

  // channel instances and their steering
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_chan
      wire [2:0] mode = ctrl_reg[g][`TITC_CTRL_MODE_POS +: 3];
      wire ext = ctrl_reg[g][`TITC_CTRL_EXT_POS] | (mode == `TITC_MODE_EVENT);
      wire tick = ext ? evt_rise[g] : pre_tick_reg; // see RULE_13
      wire gate;
      if (g < 2) begin : gen_gen
        assign gate = ctrl_reg[g][`TITC_CTRL_GSEL_POS] ?
                      gate_pio_in[g] : gate_term_in[g]; // see RULE_06
      end else begin : gen_baud
        assign gate = 1'b1; // see RULE_04
      end
      titc_counter #(
        .WIDTH(WIDTH)
      ) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode), // see RULE_03
        .bcd(ctrl_reg[g][`TITC_CTRL_BCD_POS]), // see RULE_02
        .tick(tick),
        .gate(gate),
        .load(wr_en && sel == 4'h4 + g), // see RULE_01
        .load_val(pwdata[WIDTH-1:0]),
        .sw_trig(wr_en && sel == SEL_CMD && pwdata[`TITC_CMD_TRIG_POS + g]),
        .latch_cmd(wr_en && sel == SEL_CMD && pwdata[`TITC_CMD_LATCH_POS + g]),
        .latch_rel(rd_done && sel == 4'h4 + g),
        .rd_val(cnt_val[g*WIDTH +: WIDTH]),
        .out_reg(cnt_out[g]),
        .tc_reg(cnt_tc[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////

  // internal count rate from pclk divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= `TITC_PRE_RST;
      pre_tick_reg <= 1'b0;
      evt_d_reg <= 3'h0;
    end else begin
      evt_d_reg <= evt_in;
      pre_tick_reg <= (pre_cnt_reg == 16'h0000);
      if (pre_cnt_reg == 16'h0000) pre_cnt_reg <= pre_reg;
      else pre_cnt_reg <= pre_cnt_reg - 16'h0001;
    end
  end

  // sticky terminal count flags, set beats clear
  always @* begin
    stat_next = stat_reg;
    if (wr_en && sel == SEL_STAT) stat_next = stat_reg & ~pwdata[2:0];
    stat_next = stat_next | cnt_tc; // see RULE_07
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg[0] <= `TITC_CTRL_RST;
      ctrl_reg[1] <= `TITC_CTRL_RST;
      ctrl_reg[2] <= `TITC_CTRL_RST;
      mask_reg <= `TITC_MASK_RST;
      pre_reg <= `TITC_PRE_RST;
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= stat_next;
      if (wr_en) begin
        case (sel)
          4'h0: ctrl_reg[0] <= pwdata[7:0];
          4'h1: ctrl_reg[1] <= pwdata[7:0];
          4'h2: ctrl_reg[2] <= pwdata[7:0];
          SEL_MASK: mask_reg <= pwdata[2:0];
          SEL_PRE: pre_reg <= pwdata[15:0];
          default: pre_reg <= pre_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // read data selection
  always @* begin
    rdata_next = 32'h0000_0000;
    case (sel)
      4'h0: rdata_next[7:0] = ctrl_reg[0];
      4'h1: rdata_next[7:0] = ctrl_reg[1];
      4'h2: rdata_next[7:0] = ctrl_reg[2];
      4'h4: rdata_next[WIDTH-1:0] = cnt_val[0 +: WIDTH]; // see RULE_14
      4'h5: rdata_next[WIDTH-1:0] = cnt_val[WIDTH +: WIDTH];
      4'h6: rdata_next[WIDTH-1:0] = cnt_val[2*WIDTH +: WIDTH];
      SEL_STAT: begin
        rdata_next[2:0] = stat_reg;
        rdata_next[`TITC_STAT_OUT_POS +: 3] = cnt_out;
      end
      SEL_MASK: rdata_next[2:0] = mask_reg;
      SEL_PRE: rdata_next[15:0] = pre_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // apb answer, ready in second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & (sel == SEL_NONE);
      if (acc_first && !pwrite) prdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // output routing and interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_irq_out <= 2'h0;
      port_drv_out <= 2'h0;
      port_in_out <= 2'h0;
      baud_clk_out <= 1'b1;
      irq <= 1'b0;
    end else begin
      tmr_irq_out[0] <= cnt_out[0] &
        (ctrl_reg[0][`TITC_CTRL_ROUTE_POS +: 2] == `TITC_ROUTE_IRQ); // see RULE_05
      tmr_irq_out[1] <= cnt_out[1] &
        (ctrl_reg[1][`TITC_CTRL_ROUTE_POS +: 2] == `TITC_ROUTE_IRQ);
      port_drv_out[0] <= cnt_out[0] &
        (ctrl_reg[0][`TITC_CTRL_ROUTE_POS +: 2] == `TITC_ROUTE_DRV);
      port_drv_out[1] <= cnt_out[1] &
        (ctrl_reg[1][`TITC_CTRL_ROUTE_POS +: 2] == `TITC_ROUTE_DRV);
      port_in_out[0] <= cnt_out[0] &
        (ctrl_reg[0][`TITC_CTRL_ROUTE_POS +: 2] == `TITC_ROUTE_PIO);
      port_in_out[1] <= cnt_out[1] &
        (ctrl_reg[1][`TITC_CTRL_ROUTE_POS +: 2] == `TITC_ROUTE_PIO);
      baud_clk_out <= cnt_out[2]; // see RULE_04
      irq <= |(stat_next & mask_reg); // see RULE_07
    end
  end

endmodule

// File: hw/titc_defines.vh
`ifndef TITC_DEFINES_VH
`define TITC_DEFINES_VH

// register byte offsets
`define TITC_CTRL0_OFS 8'h00
`define TITC_CTRL1_OFS 8'h04
`define TITC_CTRL2_OFS 8'h08
`define TITC_LOAD0_OFS 8'h0c
`define TITC_LOAD1_OFS 8'h10
`define TITC_LOAD2_OFS 8'h14
`define TITC_CMD_OFS 8'h18
`define TITC_STAT_OFS 8'h1c
`define TITC_MASK_OFS 8'h20
`define TITC_PRE_OFS 8'h24

// control register fields
`define TITC_CTRL_MODE_POS 0
`define TITC_CTRL_BCD_POS 3
`define TITC_CTRL_EXT_POS 4
`define TITC_CTRL_ROUTE_POS 5
`define TITC_CTRL_GSEL_POS 7

// command and status fields
`define TITC_CMD_LATCH_POS 0
`define TITC_CMD_TRIG_POS 4
`define TITC_STAT_OUT_POS 4

// output route codes
`define TITC_ROUTE_IRQ 2'h0
`define TITC_ROUTE_DRV 2'h1
`define TITC_ROUTE_PIO 2'h2

// reset values
`define TITC_CTRL_RST 8'h00
`define TITC_MASK_RST 3'h0
`define TITC_PRE_RST 16'h0000

// counting functions
`define TITC_MODE_TCINT 3'h0
`define TITC_MODE_ONESHOT 3'h1
`define TITC_MODE_RATE 3'h2
`define TITC_MODE_SQUARE 3'h3
`define TITC_MODE_SWSTRB 3'h4
`define TITC_MODE_HWSTRB 3'h5
`define TITC_MODE_EVENT 3'h6

`endif

// File: hw/titc_counter.v
`timescale 1ns/1ps
`include "titc_defines.vh"
module titc_counter #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // configuration
  input wire [2:0] mode,
  input wire bcd,
  // strobes and levels
  input wire tick,
  input wire gate,
  input wire load,
  input wire [WIDTH-1:0] load_val,
  input wire sw_trig,
  input wire latch_cmd,
  input wire latch_rel,
  // results
  output wire [WIDTH-1:0] rd_val,
  output reg out_reg,
  output reg tc_reg
);

  // decrement by one, binary or decimal digits
  function [WIDTH-1:0] dec_val;
    input [WIDTH-1:0] v;
    input b;
    integer i;
    reg borrow;
    begin
      dec_val = v - {{(WIDTH-1){1'b0}}, 1'b1};
      if (b) begin
        borrow = 1'b1;
        for (i = 0; i < WIDTH/4; i = i + 1) begin
          dec_val[i*4 +: 4] = v[i*4 +: 4];
          if (borrow) begin
            dec_val[i*4 +: 4] = (v[i*4 +: 4] == 4'h0) ? 4'h9 : v[i*4 +: 4] - 4'h1;
            borrow = (v[i*4 +: 4] == 4'h0);
          end
        end
      end
    end
  endfunction

  // half of a value, binary or decimal digits
  function [WIDTH-1:0] half_val;
    input [WIDTH-1:0] v;
    input b;
    integer i;
    reg odd;
    begin
      half_val = v >> 1;
      if (b) begin
        odd = 1'b0;
        for (i = WIDTH/4 - 1; i >= 0; i = i - 1) begin
          half_val[i*4 +: 4] = {1'b0, v[i*4+1 +: 3]} + (odd ? 4'h5 : 4'h0);
          odd = v[i*4];
        end
      end
    end
  endfunction

  reg [WIDTH-1:0] cnt_reg;
  reg [WIDTH-1:0] reload_reg;
  reg [WIDTH-1:0] latch_reg;
  reg latched_reg;
  reg run_reg;
  reg gate_d_reg;
  reg [WIDTH-1:0] cnt_next;
  reg run_next;
  reg out_next;
  reg tc_next;

  wire trig_mode = (mode == `TITC_MODE_ONESHOT) || (mode == `TITC_MODE_HWSTRB);
  wire strb_mode = (mode == `TITC_MODE_SWSTRB) || (mode == `TITC_MODE_HWSTRB);
  wire gate_rise = gate & ~gate_d_reg;
  wire step = tick & run_reg & (trig_mode | gate); // see RULE_15
  wire at_end = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1}); // see RULE_15
  wire [WIDTH-1:0] dec = dec_val(cnt_reg, bcd); // see RULE_02
  wire [WIDTH-1:0] half = half_val(reload_reg, bcd);

  // snapshot wins over live count until read
  assign rd_val = latched_reg ? latch_reg : cnt_reg; // see RULE_14

  // next state of one counting channel
  always @* begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    out_next = out_reg;
    tc_next = 1'b0;
    if (load) begin
      cnt_next = load_val;
      run_next = ~trig_mode;
      out_next = (mode != `TITC_MODE_TCINT);
    end else if (mode == `TITC_MODE_ONESHOT && (gate_rise | sw_trig)) begin
      cnt_next = reload_reg; // see RULE_08
      run_next = 1'b1;
      out_next = 1'b0;
    end else if (mode == `TITC_MODE_HWSTRB && gate_rise) begin
      cnt_next = reload_reg; // see RULE_12
      run_next = 1'b1;
      out_next = 1'b1;
    end else if (strb_mode && tick && !out_reg) begin
      out_next = 1'b1;
    end else if (step) begin
      tc_next = at_end;
      cnt_next = dec;
      case (mode)
        `TITC_MODE_TCINT: begin
          if (at_end) out_next = 1'b1; // see RULE_07
        end
        `TITC_MODE_ONESHOT: begin
          if (at_end) begin
            out_next = 1'b1; // see RULE_08
            run_next = 1'b0;
          end
        end
        `TITC_MODE_RATE: begin
          if (at_end) cnt_next = reload_reg; // see RULE_09
          out_next = at_end | (dec != {{(WIDTH-1){1'b0}}, 1'b1});
        end
        `TITC_MODE_SQUARE: begin
          if (at_end) cnt_next = reload_reg;
          out_next = (at_end ? reload_reg : dec) > half; // see RULE_10
        end
        `TITC_MODE_SWSTRB, `TITC_MODE_HWSTRB: begin
          if (at_end) begin
            out_next = 1'b0; // see RULE_11
            run_next = 1'b0;
          end
        end
        `TITC_MODE_EVENT: begin
          if (at_end) cnt_next = reload_reg; // see RULE_13
        end
        default: begin
          cnt_next = cnt_reg;
          tc_next = 1'b0;
        end
      endcase
    end
  end

  // channel state and read snapshot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {WIDTH{1'b0}};
      reload_reg <= {WIDTH{1'b0}};
      latch_reg <= {WIDTH{1'b0}};
      latched_reg <= 1'b0;
      run_reg <= 1'b0;
      gate_d_reg <= 1'b0;
      out_reg <= 1'b1;
      tc_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      out_reg <= out_next;
      tc_reg <= tc_next;
      gate_d_reg <= gate;
      if (load) reload_reg <= load_val;
      if (latch_cmd && !latched_reg) begin
        latch_reg <= cnt_reg; // see RULE_14
        latched_reg <= 1'b1;
      end else if (latch_rel) begin
        latched_reg <= 1'b0;
      end
    end
  end

endmodule

// File: testbench/titc_checker.sv
`timescale 1ns/1ps
module titc_checker (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // routed outputs
  input wire [1:0] tmr_irq_out,
  input wire [1:0] port_drv_out,
  input wire [1:0] port_in_out
);
  logic rd_q;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // read access seen one cycle back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= psel & penable & ~pwrite;
    end
  end
  ////////////////////////////////////////////////////////////////
  // bus answer timing and refusals
  chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("wait state wrong");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_ready_sel: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_bad_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  chk_rdata_hold: assert property ($changed(prdata) |-> rd_q)
    else $error("read data moved");
  // each general output goes to one place only
  chk_route_zero: assert property ($onehot0({tmr_irq_out[0], port_drv_out[0], port_in_out[0]}))
    else $error("counter 0 routed twice");
  chk_route_one: assert property ($onehot0({tmr_irq_out[1], port_drv_out[1], port_in_out[1]}))
    else $error("counter 1 routed twice");
  // main scenarios
  cov_write: cover property (pready && pwrite);
  cov_read: cover property (pready && !pwrite);
  cov_refused: cover property (pready && pslverr);
endmodule
bind titc_top titc_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .tmr_irq_out, .port_drv_out, .port_in_out);

// File: testbench/titc_ext_model.sv
`timescale 1ns/1ps
module titc_ext_model (
  // clock
  input wire pclk,
  // bench requests
  input wire [2:0] evt_en,
  // event lines
  output logic [2:0] evt_in
);
  logic [1:0] ph = 2'h0;
  initial evt_in = 3'h0;
  // one clean event edge every four clocks per enabled line
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    evt_in <= evt_en & {3{ph == 2'h0}};
  end
endmodule

// File: testbench/titc_top_bench.sv
`timescale 1ns/1ps
`include "titc_defines.vh"
module titc_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] evt_en = 3'h0;
  logic [1:0] gate_term_in = 2'h3;
  logic [1:0] gate_pio_in = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, baud_clk_out, irq;
  wire [2:0] evt_in;
  wire [1:0] tmr_irq_out, port_drv_out, port_in_out;
  wire [7:0] outs = {irq, baud_clk_out, port_in_out, port_drv_out, tmr_irq_out};
  int n_fail = 0;
  int checked = 0;
  integer seed = 32'h1762;
  logic [31:0] rd;
  logic err;
  int a, b, n;
  ////////////////////////////////////////////////////////////////
  // design and far side
  titc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .evt_in, .gate_term_in, .gate_pio_in, .tmr_irq_out,
    .port_drv_out, .port_in_out, .baud_clk_out, .irq);
  titc_ext_model ext_u (.pclk, .evt_en, .evt_in);
  // clock
  initial forever #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait for an output level, counting clocks
  task automatic wlev(input int i, input logic v, output int c);
    c = 0;
    while (outs[i] !== v && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    if (outs[i] !== v) n_fail++; // level never came
  endtask
  // decimal digits of a small count
  function automatic int to_bcd(input int v);
    return (v / 10) * 16 + v % 10;
  endfunction
  // set function and load one counter
  task automatic cfg(input int c, input logic [7:0] ctl, input logic [15:0] ld);
    apb(1'b1, `TITC_CTRL0_OFS + 8'(4 * c), {24'h00_0000, ctl});
    apb(1'b1, `TITC_LOAD0_OFS + 8'(4 * c), {16'h0000, ld});
  endtask
  // run a periodic function and measure one period
  task automatic wave(input int c, input logic [7:0] ctl, input int i, input int ld,
      input int elo, input int ehi);
    int lo, hi;
    cfg(c, ctl, 16'(ld));
    wlev(i, 1'b1, lo);
    wlev(i, 1'b0, lo);
    wlev(i, 1'b1, lo);
    wlev(i, 1'b0, hi);
    chk("low width", lo, elo);
    chk("high width", hi, ehi);
  endtask
  // verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    chk("baud in reset", baud_clk_out, 1);
    chk("irq in reset", irq, 0);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TITC_MASK_OFS, 0);
    chk("mask reset", rd, `TITC_MASK_RST);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    chk("bad write err", err, 1);
    apb(1'b0, 8'h40, 0);
    chk("bad read err", err, 1);
    apb(1'b0, `TITC_CMD_OFS, 0);
    chk("cmd reads zero", rd, 0);
    for (a = 0; a < 3; a++) begin
      n = $random(seed);
      cfg(a, 8'h07, n[15:0]);
      apb(1'b0, `TITC_LOAD0_OFS + 8'(4 * a), 0);
      chk("held count", rd, {16'h0000, n[15:0]});
      apb(1'b0, `TITC_CTRL0_OFS + 8'(4 * a), 0);
      chk("ctrl readback", rd, 7);
    end
    $display("test registers done");
    n = 3 + ($random(seed) & 15);
    apb(1'b1, `TITC_STAT_OFS, 7);
    apb(1'b1, `TITC_MASK_OFS, 1);
    cfg(0, 8'h00, 16'(n));
    wlev(7, 1'b1, b);
    chk("irq delay", b >= n - 1 && b <= n + 6, 1);
    chk("out at tc", outs[0], 1);
    apb(1'b1, `TITC_MASK_OFS, 0);
    @(posedge pclk);
    chk("irq masked", irq, 0);
    apb(1'b1, `TITC_STAT_OFS, 1);
    apb(1'b0, `TITC_STAT_OFS, 0);
    chk("stat cleared", rd[0], 0);
    $display("test interrupt done");
    n = 4 + ($random(seed) & 7);
    wave(0, 8'h22, 2, n, 1, n - 1);
    wave(1, 8'h43, 5, 2 * n, n, n);
    wave(2, 8'h0a, 6, to_bcd(n), 1, n - 1);
    apb(1'b1, `TITC_PRE_OFS, 32'h0000_0001);
    apb(1'b0, `TITC_PRE_OFS, 0);
    chk("prescale readback", rd, 1);
    wave(0, 8'h22, 2, n, 2, 2 * (n - 1));
    apb(1'b1, `TITC_PRE_OFS, 0);
    evt_en <= 3'h1;
    wave(0, 8'h32, 2, n, 4, 4 * (n - 1));
    evt_en <= 3'h0;
    $display("test waves done");
    n = 12 + ($random(seed) & 7);
    cfg(1, 8'h01, 16'(n));
    apb(1'b1, `TITC_CMD_OFS, 32'h0000_0020);
    repeat (3) @(posedge pclk);
    apb(1'b1, `TITC_CMD_OFS, 32'h0000_0020);
    wlev(1, 1'b1, b);
    chk("retriggered pulse", b >= n - 2 && b <= n + 1, 1);
    cfg(1, 8'h24, 16'(n));
    wlev(3, 1'b0, b);
    chk("strobe delay", b >= n - 3 && b <= n + 2, 1);
    wlev(3, 1'b1, b);
    chk("strobe width", b, 1);
    cfg(0, 8'ha5, 16'(n));
    repeat (2 * n) @(posedge pclk);
    chk("no strobe untriggered", outs[2], 1);
    gate_pio_in <= 2'h1;
    wlev(2, 1'b0, b);
    chk("hw strobe delay", b >= n - 2 && b <= n + 4, 1);
    wlev(2, 1'b1, b);
    chk("hw strobe width", b, 1);
    gate_pio_in <= 2'h0;
    cfg(0, 8'h40, 16'h0008);
    @(posedge pclk);
    chk("pio route low", outs[4], 0);
    wlev(4, 1'b1, b);
    chk("pio route tc", b >= 6 && b <= 10, 1);
    $display("test strobes done");
    cfg(1, 8'h02, 16'h4000);
    apb(1'b1, `TITC_CMD_OFS, 2);
    repeat (10) @(posedge pclk);
    apb(1'b0, `TITC_LOAD1_OFS, 0);
    a = rd;
    apb(1'b0, `TITC_LOAD1_OFS, 0);
    chk("latched older", a > rd && a - rd >= 14 && a - rd < 40, 1);
    gate_term_in <= 2'h1;
    apb(1'b0, `TITC_LOAD1_OFS, 0);
    a = rd;
    repeat (5) @(posedge pclk);
    apb(1'b0, `TITC_LOAD1_OFS, 0);
    chk("gate holds count", rd, a);
    gate_term_in <= 2'h3;
    n = 3 + ($random(seed) & 3);
    cfg(2, 8'h06, 16'(n));
    apb(1'b1, `TITC_STAT_OFS, 4);
    evt_en <= 3'h4;
    repeat (n - 1) @(posedge evt_in[2]);
    evt_en <= 3'h0;
    repeat (8) @(posedge pclk);
    apb(1'b0, `TITC_LOAD2_OFS, 0);
    chk("events left", rd, 1);
    apb(1'b0, `TITC_STAT_OFS, 0);
    chk("no early tc", rd[2], 0);
    evt_en <= 3'h4;
    @(posedge evt_in[2]);
    evt_en <= 3'h0;
    repeat (8) @(posedge pclk);
    apb(1'b0, `TITC_STAT_OFS, 0);
    chk("tc after events", rd[2], 1);
    $display("test latch and events done");
    report_and_stop;
  end
endmodule
